// File: logic/din_cond_consts.vh
// constants for the digital input conditioner
// assumes a 25 MHz aclk and an AXI4-Lite register bus
`ifndef DIN_COND_CONSTS_VH
`define DIN_COND_CONSTS_VH

// clock and timing
`define CLK_HZ 25000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define DEB_MIN_MS 7'd1
`define DEB_MAX_MS 7'd100
`define DEB_RESET_MS 7'd10

// input count: two standard plus up to twelve optional
`define NUM_INPUTS 14

// register byte offsets
`define REG_CTRL 8'h00
`define REG_INPOL 8'h04
`define REG_PULPOL 8'h08
`define REG_MODE 8'h0c
`define REG_STATE 8'h10
`define REG_EVSTAT 8'h14
`define REG_EVCLR 8'h18
`define REG_EVEN 8'h1c
`define REG_OPTION 8'h20

// control register fields
`define CTRL_DEB_LSB 0
`define CTRL_DEB_MSB 6

// option build: 0 none, 1 four, 2 eight, 3 twelve
`define OPT_RESET 2'd0

`endif

// File: logic/digital_input_pulse_conditioner.v
// digital input conditioner: sync, debounce, polarity, edge events
// assumes raw contact inputs asynchronous to aclk and an AXI4-Lite master
//
// Overview of operation
// - two standard inputs plus optional four, eight or twelve, all identical
// - each input gives status-change events and count pulses downstream
// - normal input polarity: closed contact is closed; inverting flips it
// - pulse mode: one event per pulse on the edge chosen by polarity
// - transition-pulse mode: an event on every leading and trailing edge
// - normal pulse polarity counts open-to-closed; inverting counts closed-to-open
// - transition-pulse mode ignores pulse polarity
// - new state accepted after stable for debounce time, 1 to 100 ms, default 10
// - one debounce time shared by every input
`timescale 1ns/1ps
`default_nettype none
`include "din_cond_consts.vh"

module digital_input_pulse_conditioner (
    input wire aclk,
    input wire aresetn,
    input wire [13:0] contact_in,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [13:0] input_state,
    output reg [13:0] status_event,
    output reg [13:0] count_pulse,
    output reg irq
);

    localparam N = `NUM_INPUTS;

    // active inputs mask for the option build
    function [13:0] active_mask;
        input [1:0] opt;
        begin
            case (opt)
                2'd1: active_mask = 14'h003f;
                2'd2: active_mask = 14'h03ff;
                2'd3: active_mask = 14'h3fff;
                default: active_mask = 14'h0003;
            endcase
        end
    endfunction

    // clamp a debounce setting into 1..100 ms
    function [6:0] clamp_deb;
        input [6:0] v;
        begin
            if (v < `DEB_MIN_MS)
                clamp_deb = `DEB_MIN_MS;
            else if (v > `DEB_MAX_MS)
                clamp_deb = `DEB_MAX_MS;
            else
                clamp_deb = v;
        end
    endfunction

    // counted edge of one input from its mode and pulse polarity
    function count_select;
        input trans;
        input inv;
        input up;
        input down;
        begin
            if (trans)
                count_select = up | down;
            else if (inv)
                count_select = down;
            else
                count_select = up;
        end
    endfunction

    reg [6:0] deb_ms;
    reg [13:0] in_pol;
    reg [13:0] pulse_pol;
    reg [13:0] transition_pulse_mode;
    reg [1:0] option;
    reg [13:0] ev_enable;
    reg [13:0] ev_status;
    reg [13:0] sync1;
    reg [13:0] sync2;
    reg [13:0] accepted;
    reg [6:0] deb_cnt [0:13];
    reg [14:0] tick_div;
    reg tick;
    reg [13:0] next_accepted;
    reg [13:0] rise;
    reg [13:0] fall;
    reg [13:0] ev_now;
    reg [13:0] cnt_now;
    reg [13:0] mask;
    reg [31:0] wdat;
    reg [7:0] waddr;
    reg aw_held;
    reg w_held;
    reg [13:0] clr_req;
    reg [13:0] next_ev_status;
    integer i;
    integer j;

    // millisecond tick enable from the clock divider
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_div <= 15'h0000;
            tick <= 1'b0;
        end else if (tick_div == (`TICK_CYCLES - 1)) begin
            tick_div <= 15'h0000;
            tick <= 1'b1;
        end else begin
            tick_div <= tick_div + 15'h0001;
            tick <= 1'b0;
        end
    end

    // two-flop synchroniser per raw contact
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 14'h0000;
            sync2 <= 14'h0000;
        end else begin
            sync1 <= contact_in;
            sync2 <= sync1;
        end
    end

    // per-input debounce, shared time setting, inputs beyond the build held open
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (j = 0; j < N; j = j + 1)
                deb_cnt[j] <= 7'h00;
        end else begin
            for (j = 0; j < N; j = j + 1) begin
                if (sync2[j] == accepted[j] || !mask[j])
                    deb_cnt[j] <= 7'h00;
                else if (tick)
                    deb_cnt[j] <= deb_cnt[j] + 7'h01;
            end
        end
    end

    // inputs present in the option build
    always @* begin
        mask = active_mask(option);
    end

    // acceptance and edge detection in the contact domain
    always @* begin
        next_accepted = accepted;
        for (i = 0; i < N; i = i + 1) begin
            // one shared debounce time; the first tick is partial, so a full time has passed here
            if (mask[i] && sync2[i] != accepted[i] && tick && deb_cnt[i] >= deb_ms)
                next_accepted[i] = sync2[i];
        end
        rise = next_accepted & ~accepted; // open-to-closed
        fall = accepted & ~next_accepted; // closed-to-open
        // status change event on either accepted edge, input polarity not applied
        ev_now = rise | fall;
        for (i = 0; i < N; i = i + 1)
            cnt_now[i] = count_select(transition_pulse_mode[i], pulse_pol[i], rise[i], fall[i]);
    end

    // accepted state and event outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            accepted <= 14'h0000;
            input_state <= 14'h0000;
            status_event <= 14'h0000;
            count_pulse <= 14'h0000;
        end else begin
            accepted <= next_accepted;
            input_state <= (next_accepted ^ in_pol) & mask;
            status_event <= ev_now;
            count_pulse <= cnt_now;
        end
    end

    // next sticky status: a new event wins over a clear in the same cycle
    always @* begin
        next_ev_status = (ev_status & ~clr_req) | ev_now;
    end

    // sticky event status register
    always @(posedge aclk) begin
        if (!aresetn) begin
            ev_status <= 14'h0000;
        end else begin
            ev_status <= next_ev_status;
        end
    end

    // level interrupt, high while an enabled status bit is set
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_ev_status & ev_enable);
        end
    end

    // write path: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= 8'h00;
            wdat <= 32'h00000000;
            deb_ms <= `DEB_RESET_MS;
            in_pol <= 14'h0000;
            pulse_pol <= 14'h0000;
            transition_pulse_mode <= 14'h0000;
            option <= `OPT_RESET;
            ev_enable <= 14'h0000;
            clr_req <= 14'h0000;
        end else begin
            clr_req <= 14'h0000;
            if (s_axi_awvalid && s_axi_awready) begin
                waddr <= s_axi_awaddr[7:0];
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdat <= s_axi_wdata;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (waddr)
                    `REG_CTRL: deb_ms <= clamp_deb(wdat[`CTRL_DEB_MSB:`CTRL_DEB_LSB]);
                    `REG_INPOL: in_pol <= wdat[13:0];
                    `REG_PULPOL: pulse_pol <= wdat[13:0];
                    `REG_MODE: transition_pulse_mode <= wdat[13:0];
                    `REG_EVCLR: clr_req <= wdat[13:0];
                    `REG_EVEN: ev_enable <= wdat[13:0];
                    `REG_OPTION: option <= wdat[1:0];
                    `REG_STATE, `REG_EVSTAT: s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read path: one read at a time, answer one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr[7:0])
                `REG_CTRL: s_axi_rdata <= {25'h0000000, deb_ms};
                `REG_INPOL: s_axi_rdata <= {18'h00000, in_pol};
                `REG_PULPOL: s_axi_rdata <= {18'h00000, pulse_pol};
                `REG_MODE: s_axi_rdata <= {18'h00000, transition_pulse_mode};
                `REG_STATE: s_axi_rdata <= {18'h00000, input_state};
                `REG_EVSTAT: s_axi_rdata <= {18'h00000, ev_status};
                `REG_EVCLR: s_axi_rdata <= 32'h00000000;
                `REG_EVEN: s_axi_rdata <= {18'h00000, ev_enable};
                `REG_OPTION: s_axi_rdata <= {30'h00000000, option};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: verification/din_checker.sv
// port checker for the digital input conditioner
// assumes binding into the conditioner top, one aclk domain
`timescale 1ns/1ps
`default_nettype none
module din_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [13:0] input_state,
    input wire logic [13:0] status_event,
    input wire logic [13:0] count_pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus handshakes
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during response");
    // events are single-cycle and tied to accepted state changes
    a_event_single: assert property (|status_event |=> (status_event & $past(status_event)) == 14'h0)
        else $error("event longer than one cycle");
    a_count_in_event: assert property ((count_pulse & ~status_event) == 14'h0)
        else $error("count without event");
    a_event_moves_state: assert property (|status_event |-> input_state != $past(input_state))
        else $error("event without state change");
endmodule
`default_nettype wire

// File: verification/contact_bank.sv
// bouncing dry contacts in front of the conditioner
// assumes target levels from the bench, 1 = closed
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
    input wire logic aclk,
    input wire logic [13:0] target,
    output logic [13:0] contact = 14'h0
);
    logic [13:0] last = 14'h0;
    logic [3:0] bounce = 4'h0;
    // every contact chatters for a few cycles after any change
    always @(posedge aclk) begin
        if (target != last) begin
            last <= target;
            bounce <= 4'h9;
        end else if (bounce != 4'h0) begin
            bounce <= bounce - 4'h1;
        end
        contact <= (bounce[0]) ? ~target : target;
    end
endmodule
`default_nettype wire

// File: verification/tb_digital_input_pulse_conditioner.sv
// bench for the digital input conditioner
// assumes the 25000-cycle millisecond tick of the design header
`timescale 1ns/1ps
`default_nettype none
`include "din_cond_consts.vh"
module tb_digital_input_pulse_conditioner;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
    logic [13:0] target = 14'h0, ev, cp;
    logic [1:0] rr;
    wire logic awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [13:0] contact, input_state, status_event, count_pulse;
    int checks = 0, mismatches = 0, cycles = 0;
    contact_bank u_bank (.aclk(aclk), .target(target), .contact(contact));
    digital_input_pulse_conditioner u_dut (.aclk(aclk), .aresetn(aresetn), .contact_in(contact),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .input_state(input_state), .status_event(status_event),
        .count_pulse(count_pulse), .irq(irq));
    // clock and hang guard
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 110000) begin
            mismatches++;
            conclude();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        check({30'h0, bresp}, (a > `REG_OPTION) ? 32'h2 : 32'h0);
        bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rr);
        check(rd, exp);
        check({30'h0, rr}, 32'h0);
    endtask
    // gather events and counted edges until every input has reported
    task settle();
        int n;
        ev = 14'h0;
        cp = 14'h0;
        n = 0;
        while (ev != 14'h3fff && n < 60000) begin
            @(posedge aclk);
            ev |= status_event;
            cp |= count_pulse;
            n++;
        end
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(`REG_CTRL, 32'ha);
        rdchk(`REG_INPOL, 32'h0);
        rdchk(`REG_PULPOL, 32'h0);
        rdchk(`REG_MODE, 32'h0);
        axi_read(8'h3c, rd, rr);
        check(rd, 32'h0);
        check({30'h0, rr}, 32'h2);
        axi_write(8'h3c, 32'h0);
        $display("test reset values done");
        axi_write(`REG_CTRL, 32'h0);
        rdchk(`REG_CTRL, 32'h1);
        axi_write(`REG_CTRL, 32'h7f);
        rdchk(`REG_CTRL, 32'h64);
        axi_write(`REG_CTRL, 32'h1);
        axi_write(`REG_OPTION, 32'h3);
        axi_write(`REG_EVEN, 32'h3fff);
        axi_write(`REG_MODE, 32'h3fff);
        axi_write(`REG_PULPOL, 32'h2aaa);
        $display("test debounce clamp done");
        target <= 14'h3fff;
        settle();
        check(cp, 14'h3fff);
        check(ev, 14'h3fff);
        check(input_state, 14'h3fff);
        check(irq, 1'b1);
        rdchk(`REG_EVSTAT, 32'h3fff);
        axi_write(`REG_EVCLR, 32'h3fff);
        rdchk(`REG_EVSTAT, 32'h0);
        check(irq, 1'b0);
        $display("test transition mode done");
        axi_write(`REG_MODE, 32'h0);
        axi_write(`REG_PULPOL, 32'hff);
        axi_write(`REG_INPOL, 32'h2);
        rdchk(`REG_INPOL, 32'h2);
        check(input_state, 14'h3ffd);
        target <= 14'h0;
        settle();
        check(cp, 14'h00ff);
        check(input_state, 14'h0002);
        $display("test pulse mode done");
        conclude();
    end
endmodule
bind digital_input_pulse_conditioner din_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .input_state(input_state),
    .status_event(status_event), .count_pulse(count_pulse));
`default_nettype wire
